// ==== iit_coproc_model.sv ====
// Purpose: Behavioural co-processor on the far side of the issue block.
// Assumes: The move qualifiers are valid while the decode strobe is high.
// Notes:   The status register counts single moves low and double moves high.
module iit_coproc_model (
   input  wire logic        clk_in,     // Core input clock.
   input  wire logic        nrst_in,    // Synchronous reset, active low.
   input  wire logic        strobe_in,  // Co-processor instruction in decode.
   input  wire logic        single_in,  // Decoded one is a single move.
   input  wire logic        double_in,  // Decoded one is a double move.
   output logic [15:0]      ctrl_out,   // Operating mode control register.
   output logic [15:0]      status_out  // Moves seen since reset.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic half;
   // A strobe stands two clocks per instruction and stays high across back-to-back
   // instructions, so a move is counted on every other clock while it stands.
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         half       <= 1'h0;
         ctrl_out   <= 16'h0001;
         status_out <= 16'h0000;
      end else begin
         half <= strobe_in && !half;
         if (strobe_in && !half) begin
            status_out <= status_out + {7'h00, double_in, 7'h00, single_in};
         end
      end
   end
endmodule : iit_coproc_model

// ==== iit_issue.sv ====
// Purpose: Sets fetch word count and issue spacing per instruction group,
//          and strobes the co-processor during decode of its instructions.
// Assumes: Decoded instructions arrive on clk_in from same-domain logic.
// Notes:   Counts are in instruction cycles; each is two clk_in periods.

// Functional notes
// - Three stage pipeline, cycle is two clocks
// - One word fetched per cycle, execute two later
// - Register move: one word, one cycle
// - Program memory transfer: one word, four cycles
// - Flow: two/three cycles, delayed one/two
// - Single repeat below 512: one word, one cycle
// - Single repeat 512 up: two words, two cycles
// - Block repeat below 512: two words, two cycles
// - Block repeat 512 up: two or three words
// - Double push/pop register: one word, one cycle
// - Direct push/pop: two words, three cycles
// - Direct double push/pop: two words, three cycles
// - Indexed stack move: one word, two cycles
// - Strobe co-processor while decoding its instruction
// - Co-processor moves are one word each
module iit_issue
   import iit_pkg::*;
(
   input  wire logic       clk_in,                 // Core input clock.
   input  wire logic       nrst_in,                // Synchronous reset, active low.
   input  wire iit_instr_t instr_in,               // Decoded instruction.
   input  wire logic       instr_valid_in,         // Decoded instruction is offered.
   output logic            issue_ready_out,        // Decode stage may offer.
   output logic            cycle_phase_out,        // High on second clock of a cycle.
   output logic            fetch_out,              // Program word fetch strobe.
   output logic            exec_start_out,         // First execute cycle of an instruction.
   output logic [1:0]      words_out,              // Words of the issued instruction.
   output logic [2:0]      cycles_out,             // Cycles of the issued instruction.
   output logic            coproc_instr_strobe_out, // Co-processor instruction in decode.
   output logic            coproc_single_move_out,  // Decoded one is a single move.
   output logic            coproc_double_move_out   // Decoded one is a double move.
);

   // ****************************************************************
   // Cost lookup
   // ****************************************************************
   function automatic iit_cost_t cost_of(input iit_instr_t ins);
      logic big;
      big = (ins.rep_count >= 16'(IIT_REP_THRESH));
      case (ins.group)
         IIT_G_REG_MOVE:   cost_of = '{words: 2'd1, cycles: 3'd1};
         IIT_G_PROGRAM_RAM_XFER:  cost_of = '{words: 2'd1, cycles: 3'd4};
         IIT_G_FLOW:       cost_of = '{words: 2'd1,
                                       cycles: ins.flow_long ? 3'd3 : 3'd2};
         IIT_G_FLOW_DLY:   cost_of = '{words: 2'd1,
                                       cycles: ins.flow_long ? 3'd2 : 3'd1};
         IIT_G_REP_SINGLE: cost_of = big ? iit_cost_t'{words: 2'd2, cycles: 3'd2}
                                         : iit_cost_t'{words: 2'd1, cycles: 3'd1};
         IIT_G_REP_BLOCK:  cost_of = (big && ins.block_long)
                                   ? iit_cost_t'{words: 2'd3, cycles: 3'd3}
                                   : iit_cost_t'{words: 2'd2, cycles: 3'd2};
         IIT_G_DSTACK_REG: cost_of = '{words: 2'd1, cycles: 3'd1};
         IIT_G_STACK_DIR:  cost_of = '{words: 2'd2, cycles: 3'd3};
         IIT_G_DSTACK_DIR: cost_of = '{words: 2'd2, cycles: 3'd3};
         IIT_G_STACK_IDX:  cost_of = '{words: 2'd1, cycles: 3'd2};
         IIT_G_COP_SINGLE,
         IIT_G_COP_DOUBLE: cost_of = '{words: 2'd1, cycles: 3'd1};
         default:          cost_of = '{words: 2'd1, cycles: 3'd1};
      endcase
   endfunction : cost_of

   // ****************************************************************
   // Cycle phase and issue sequencing
   // ****************************************************************
   iit_state_t state;
   iit_state_t next_state;
   logic       phase;
   logic [2:0] remain;
   logic [2:0] next_remain;
   logic [1:0] fetch_left;
   logic [1:0] next_fetch_left;
   logic [1:0] exec_pipe;
   iit_cost_t  cost;
   logic       take;
   logic       is_cop_s;
   logic       is_cop_d;

   assign cost     = cost_of(instr_in);
   // Issue happens on the last clock of an instruction cycle only.
   assign take     = phase && instr_valid_in && (remain <= 3'd1);
   assign is_cop_s = instr_valid_in && (instr_in.group == IIT_G_COP_SINGLE);
   assign is_cop_d = instr_valid_in && (instr_in.group == IIT_G_COP_DOUBLE);

   always_comb begin
      next_state      = state;
      next_remain     = remain;
      next_fetch_left = fetch_left;
      if (phase) begin
         if (remain > 3'd1) begin
            next_remain = remain - 3'd1;
            next_state  = IIT_S_HOLD;
         end else if (take) begin
            next_remain = cost.cycles;
            next_state  = IIT_S_ISSUE;
         end else begin
            next_remain = 3'd0;
            next_state  = IIT_S_IDLE;
         end
         if (take) begin
            next_fetch_left = cost.words - 2'd1;
         end else if (fetch_left != 2'd0) begin
            next_fetch_left = fetch_left - 2'd1;
         end
      end
      case (state)
         IIT_S_IDLE, IIT_S_ISSUE, IIT_S_HOLD: ;
         default: next_state = IIT_S_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state      <= IIT_S_IDLE;
         phase      <= 1'b0;
         remain     <= IIT_RESET_CYCLES;
         fetch_left <= IIT_RESET_WORDS;
         exec_pipe  <= 2'b00;
      end else begin
         state      <= next_state;
         phase      <= ~phase;
         remain     <= next_remain;
         fetch_left <= next_fetch_left;
         if (phase) begin
            exec_pipe <= {exec_pipe[0], take};
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         issue_ready_out         <= 1'b0;
         cycle_phase_out         <= 1'b0;
         fetch_out               <= 1'b0;
         exec_start_out          <= 1'b0;
         words_out               <= IIT_RESET_WORDS;
         cycles_out              <= IIT_RESET_CYCLES;
         coproc_instr_strobe_out <= 1'b0;
         coproc_single_move_out  <= 1'b0;
         coproc_double_move_out  <= 1'b0;
      end else begin
         cycle_phase_out <= ~phase;
         issue_ready_out <= (next_remain <= 3'd1);
         if (phase) begin
            fetch_out      <= take || (fetch_left != 2'd0);
            exec_start_out <= exec_pipe[1];
            if (take) begin
               words_out  <= cost.words;
               cycles_out <= cost.cycles;
            end
            // Strobe covers the decode cycle; execute starts two cycles after it starts.
            coproc_instr_strobe_out <= take && (is_cop_s || is_cop_d);
            coproc_single_move_out  <= take && is_cop_s;
            coproc_double_move_out  <= take && is_cop_d;
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_phase_toggle;
      @(posedge clk_in) disable iff (!nrst_in)
      $past(nrst_in) |-> (phase != $past(phase));
   endproperty
   a_phase_toggle: assert property (p_phase_toggle)
      else $error("cycle phase did not alternate");

   property p_program_ram_hold;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_PROGRAM_RAM_XFER) |=> !take [*7];
   endproperty
   a_program_ram_hold: assert property (p_program_ram_hold)
      else $error("issue during program memory transfer");

   property p_regmove_cost;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_REG_MOVE) |=> (cycles_out == 3'd1 && words_out == 2'd1);
   endproperty
   a_regmove_cost: assert property (p_regmove_cost)
      else $error("register move cost wrong");

   property p_rep_small;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_REP_SINGLE && instr_in.rep_count < 16'd512)
      |=> (words_out == 2'd1 && cycles_out == 3'd1);
   endproperty
   a_rep_small: assert property (p_rep_small)
      else $error("short single repeat cost wrong");

   property p_rep_big;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_REP_SINGLE && instr_in.rep_count >= 16'd512)
      |=> (words_out == 2'd2 && cycles_out == 3'd2);
   endproperty
   a_rep_big: assert property (p_rep_big)
      else $error("long single repeat cost wrong");

   property p_stack_dir;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_STACK_DIR) |=> !take [*5];
   endproperty
   a_stack_dir: assert property (p_stack_dir)
      else $error("direct push or pop issued too soon");

   property p_stack_idx;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_STACK_IDX) |=> (cycles_out == 3'd2 && words_out == 2'd1);
   endproperty
   a_stack_idx: assert property (p_stack_idx)
      else $error("indexed stack move cost wrong");

   property p_cop_strobe;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && (is_cop_s || is_cop_d)) |=> coproc_instr_strobe_out ##1 coproc_instr_strobe_out;
   endproperty
   a_cop_strobe: assert property (p_cop_strobe)
      else $error("co-processor strobe missing");

   // Clocks since the last issue, saturating; checks spacing apart from the hold counter.
   logic [3:0] gap;
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         gap <= 4'hF;
      end else if (take) begin
         gap <= 4'h1;
      end else if (gap != 4'hF) begin
         gap <= gap + 4'h1;
      end
   end

   property p_hold_count;
      @(posedge clk_in) disable iff (!nrst_in)
      take |-> (gap >= {cycles_out, 1'b0});
   endproperty
   a_hold_count: assert property (p_hold_count)
      else $error("issue while holding");

   property p_exec_delay;
      @(posedge clk_in) disable iff (!nrst_in)
      take |-> ##5 exec_start_out;
   endproperty
   a_exec_delay: assert property (p_exec_delay)
      else $error("execute not two cycles after fetch");

   property p_flow_long;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_FLOW && instr_in.flow_long)
      |=> (words_out == 2'h1 && cycles_out == 3'h3);
   endproperty
   a_flow_long: assert property (p_flow_long)
      else $error("long flow change cost wrong");

   property p_flow_dly;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_FLOW_DLY && !instr_in.flow_long)
      |=> (words_out == 2'h1 && cycles_out == 3'h1);
   endproperty
   a_flow_dly: assert property (p_flow_dly)
      else $error("short delayed flow change cost wrong");

   property p_block_small;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_REP_BLOCK && instr_in.rep_count < 16'(IIT_REP_THRESH))
      |=> (words_out == 2'h2 && cycles_out == 3'h2);
   endproperty
   a_block_small: assert property (p_block_small)
      else $error("short block repeat cost wrong");

   property p_block_big;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_REP_BLOCK && instr_in.block_long
       && instr_in.rep_count >= 16'(IIT_REP_THRESH)) |=> (words_out == 2'h3 && cycles_out == 3'h3);
   endproperty
   a_block_big: assert property (p_block_big)
      else $error("long block repeat cost wrong");

   property p_dstack_reg;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_DSTACK_REG) |=> (cycles_out == 3'h1 && words_out == 2'h1);
   endproperty
   a_dstack_reg: assert property (p_dstack_reg)
      else $error("double register push or pop cost wrong");

   property p_dstack_dir;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && instr_in.group == IIT_G_DSTACK_DIR) |=> !take [*5];
   endproperty
   a_dstack_dir: assert property (p_dstack_dir)
      else $error("direct double push or pop issued too soon");

   property p_cop_kind;
      @(posedge clk_in) disable iff (!nrst_in)
      (take && is_cop_d)
      |=> (coproc_double_move_out && !coproc_single_move_out && words_out == 2'h1);
   endproperty
   a_cop_kind: assert property (p_cop_kind)
      else $error("co-processor double move not flagged");

   c_program_ram:  cover property (@(posedge clk_in) disable iff (!nrst_in)
                            take && instr_in.group == IIT_G_PROGRAM_RAM_XFER);
   c_cop:   cover property (@(posedge clk_in) disable iff (!nrst_in) coproc_double_move_out);
   c_block: cover property (@(posedge clk_in) disable iff (!nrst_in)
                            take && cost.words == 2'd3);
   c_rep_big: cover property (@(posedge clk_in) disable iff (!nrst_in)
                              take && instr_in.group == IIT_G_REP_SINGLE && cost.words == 2'h2);
   c_hold:  cover property (@(posedge clk_in) disable iff (!nrst_in) state == IIT_S_HOLD);

endmodule : iit_issue

// ==== iit_issue_tb.sv ====
// Purpose: Self-checking bench for the instruction issue timing block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Reset cases, one or more table rows per instruction group, then hand-written cases.
module iit_issue_tb
   import iit_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {iit_instr_t i; logic [1:0] w; logic [2:0] c;} iit_row_t;
   logic        clk_in = 1'h0;
   logic        nrst_in = 1'h0;
   iit_instr_t  instr = '0;
   logic        valid = 1'h0;
   logic        ready, phase, fetch, exec, strobe, single, dbl;
   logic [1:0]  words;
   logic [2:0]  cycles;
   logic [15:0] ctrl, status;
   int          errors = 0;
   int          checks = 0;
   iit_row_t    rows[18];

   always #10 clk_in = ~clk_in;

   iit_issue dut (.clk_in(clk_in), .nrst_in(nrst_in), .instr_in(instr),
      .instr_valid_in(valid), .issue_ready_out(ready), .cycle_phase_out(phase),
      .fetch_out(fetch), .exec_start_out(exec), .words_out(words),
      .cycles_out(cycles), .coproc_instr_strobe_out(strobe),
      .coproc_single_move_out(single), .coproc_double_move_out(dbl));
   iit_coproc_model cop (.clk_in(clk_in), .nrst_in(nrst_in), .strobe_in(strobe),
      .single_in(single), .double_in(dbl), .ctrl_out(ctrl), .status_out(status));

   function automatic iit_row_t mk(iit_group_t g, logic [15:0] n, logic l,
                                    logic [1:0] w, logic [2:0] c);
      return '{'{g, n, l, l}, w, c};
   endfunction : mk

   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'h1) begin
         errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim

   // Returns after the rising edge on which the offered instruction is taken.
   task automatic wait_take;
      for (int n = 0; n < 20; n++) begin
         if (ready === 1'h1 && phase === 1'h1) break;
         @(negedge clk_in);
      end
      chk(ready === 1'h1 && phase === 1'h1, "never ready");
      @(posedge clk_in);
   endtask : wait_take

   task automatic run_row(input iit_row_t r);
      int f, e, s, first, rdy;
      logic last;
      f = 0; e = 0; s = 0; first = 0; rdy = 0;
      @(negedge clk_in);
      instr = r.i;
      valid = 1'h1;
      wait_take();
      @(negedge clk_in);
      valid = 1'h0;
      chk(words === r.w && cycles === r.c, "cost");
      last = ~phase;
      for (int k = 1; k <= 10; k++) begin
         chk(phase === ~last, "phase");
         last = phase;
         f += int'(fetch === 1'h1);
         e += int'(exec === 1'h1);
         s += int'(strobe === 1'h1);
         if (exec === 1'h1 && first == 0) first = k;
         if (ready === 1'h1 && phase === 1'h1 && rdy == 0) rdy = k;
         if (strobe === 1'h1) chk(single === (r.i.group == IIT_G_COP_SINGLE)
            && dbl === (r.i.group == IIT_G_COP_DOUBLE), "kind");
         @(negedge clk_in);
      end
      chk(rdy == 2 * int'(r.c), "spacing");
      chk(f == 2 * int'(r.w) && first == 5 && e == 2, "fetch");
      chk(s == (r.i.group inside {IIT_G_COP_SINGLE, IIT_G_COP_DOUBLE} ? 2 : 0), "strobe");
   endtask : run_row

   initial begin
      #100000;
      errors++;
      end_sim();
   end

   initial begin
      rows = '{mk(IIT_G_REG_MOVE, 16'h0000, 1'h0, 2'h1, 3'h1),
               mk(IIT_G_PROGRAM_RAM_XFER, 16'h0000, 1'h0, 2'h1, 3'h4),
               mk(IIT_G_FLOW, 16'h0000, 1'h0, 2'h1, 3'h2),
               mk(IIT_G_FLOW, 16'h0000, 1'h1, 2'h1, 3'h3),
               mk(IIT_G_FLOW_DLY, 16'h0000, 1'h0, 2'h1, 3'h1),
               mk(IIT_G_FLOW_DLY, 16'h0000, 1'h1, 2'h1, 3'h2),
               mk(IIT_G_REP_SINGLE, 16'h01ff, 1'h0, 2'h1, 3'h1),
               mk(IIT_G_REP_SINGLE, 16'h0200, 1'h0, 2'h2, 3'h2),
               mk(IIT_G_REP_BLOCK, 16'h01ff, 1'h1, 2'h2, 3'h2),
               mk(IIT_G_REP_BLOCK, 16'h0200, 1'h0, 2'h2, 3'h2),
               mk(IIT_G_REP_BLOCK, 16'hffff, 1'h1, 2'h3, 3'h3),
               mk(IIT_G_DSTACK_REG, 16'h0000, 1'h0, 2'h1, 3'h1),
               mk(IIT_G_STACK_DIR, 16'h0000, 1'h0, 2'h2, 3'h3),
               mk(IIT_G_DSTACK_DIR, 16'h0000, 1'h0, 2'h2, 3'h3),
               mk(IIT_G_STACK_IDX, 16'h0000, 1'h0, 2'h1, 3'h2),
               mk(IIT_G_COP_SINGLE, 16'h0000, 1'h0, 2'h1, 3'h1),
               mk(IIT_G_COP_DOUBLE, 16'h0000, 1'h0, 2'h1, 3'h1),
               mk(IIT_G_OTHER, 16'h0000, 1'h0, 2'h1, 3'h1)};
      repeat (2) @(negedge clk_in);
      chk({ready, phase, fetch, exec, words, cycles, strobe, single, dbl} === '0, "reset");
      nrst_in = 1'h1;
      // Reset in the middle of a long hold must clear every issue output except the two move flags.
      instr = rows[1].i;
      valid = 1'h1;
      wait_take();
      repeat (2) @(negedge clk_in);
      valid = 1'h0;
      nrst_in = 1'h0;
      repeat (2) @(negedge clk_in);
      chk({ready, phase, fetch, exec, words, cycles, strobe} === '0, "mid reset");
      nrst_in = 1'h1;
      foreach (rows[i]) run_row(rows[i]);
      // A second request held during a long transfer must wait out the hold.
      @(negedge clk_in);
      instr = rows[1].i;
      valid = 1'h1;
      wait_take();
      @(negedge clk_in);
      instr = rows[15].i;
      repeat (7) begin
         chk(cycles === 3'h4 && strobe === 1'h0, "early issue");
         @(negedge clk_in);
      end
      @(negedge clk_in);
      chk(cycles === 3'h1 && strobe === 1'h1 && single === 1'h1, "late");
      // Two double moves straight after keep the strobe high for three cycles.
      instr = rows[16].i;
      repeat (2) @(negedge clk_in);
      chk(strobe === 1'h1 && dbl === 1'h1 && single === 1'h0, "back to back");
      repeat (2) @(negedge clk_in);
      valid = 1'h0;
      repeat (4) @(negedge clk_in);
      chk(status === 16'h0302 && ctrl === 16'h0001, "moves");
      end_sim();
   end
endmodule : iit_issue_tb

// ==== iit_pkg.sv ====
// Purpose: Shared constants and types for the instruction issue timing block.
// Assumes: One instruction cycle equals two periods of the core input clock.
// Notes:   Group codes are assigned by the decoder that feeds this block.
package iit_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned IIT_CLK_PER_CYCLE = 2;
   localparam int unsigned IIT_EXEC_DELAY    = 2;
   localparam int unsigned IIT_REP_THRESH    = 512;

   // ****************************************************************
   // Instruction groups
   // ****************************************************************
   typedef enum logic [3:0] {
      IIT_G_REG_MOVE    = 4'h0,
      IIT_G_PROGRAM_RAM_XFER   = 4'h1,
      IIT_G_FLOW        = 4'h2,
      IIT_G_FLOW_DLY    = 4'h3,
      IIT_G_REP_SINGLE  = 4'h4,
      IIT_G_REP_BLOCK   = 4'h5,
      IIT_G_DSTACK_REG  = 4'h6,
      IIT_G_STACK_DIR   = 4'h7,
      IIT_G_DSTACK_DIR  = 4'h8,
      IIT_G_STACK_IDX   = 4'h9,
      IIT_G_COP_SINGLE  = 4'hA,
      IIT_G_COP_DOUBLE  = 4'hB,
      IIT_G_OTHER       = 4'hF
   } iit_group_t;

   // Decoded instruction as offered by the decode stage.
   typedef struct packed {
      iit_group_t  group;       // Instruction group.
      logic [15:0] rep_count;   // Repeat count for repeat groups.
      logic        flow_long;   // Flow change takes its longer timing.
      logic        block_long;  // Block repeat with a separate end word.
   } iit_instr_t;

   // Issue timing for one instruction.
   typedef struct packed {
      logic [1:0] words;
      logic [2:0] cycles;
   } iit_cost_t;

   localparam logic [1:0] IIT_RESET_WORDS  = 2'h0;
   localparam logic [2:0] IIT_RESET_CYCLES = 3'h0;

   typedef enum logic [1:0] {
      IIT_S_IDLE  = 2'b00,
      IIT_S_ISSUE = 2'b01,
      IIT_S_HOLD  = 2'b10
   } iit_state_t;

endpackage : iit_pkg
